// ---- pkg/vdib_map.vh ----
// register map, field positions and reset values of the demapper interrupt bank
`ifndef VDIB_MAP_VH
`define VDIB_MAP_VH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define VDIB_IDX_STAT0 10'h067
`define VDIB_IDX_EN2 10'h068
`define VDIB_IDX_EN1 10'h069
`define VDIB_IDX_EN0 10'h06b
`define VDIB_IDX_STAT1 10'h070
`define VDIB_IDX_STAT2 10'h071

// ************************************************************
// status register 0 fields
// ************************************************************
`define VDIB_S0_PTM_UNST 5
`define VDIB_S0_NEW_PTM 4
`define VDIB_S0_TIM 3
`define VDIB_S0_MASK 8'h38

// ************************************************************
// enable register 1 / status register 1 fields
// ************************************************************
`define VDIB_E1_SIZE_ERR 7
`define VDIB_E1_LOP 6
`define VDIB_E1_RFI 5
`define VDIB_E1_RDI 4
`define VDIB_E1_AIS_FAIL 3
`define VDIB_E1_AIS_DEF 2
`define VDIB_E1_LABEL 1
`define VDIB_E1_E1AIS 0
`define VDIB_E1_MASK 8'hff

// ************************************************************
// enable register 2 / status register 2 fields
// ************************************************************
`define VDIB_E2_APS 1
`define VDIB_E2_ES_OVF 0
`define VDIB_E2_MASK 8'h03

// ************************************************************
// reset values
// ************************************************************
`define VDIB_RST_EN 8'h00
`define VDIB_RST_STAT 8'h00

`endif

// ---- hdl/vdib_evt_latch.v ----
// sticky clear-on-read event latch, set wins over clear
`timescale 1ns/1ns

module vdib_evt_latch #(
   parameter W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] evt,
   input wire [W-1:0] clr,
   output reg [W-1:0] status_q
);

   // ************************************************************
   // latch
   // ************************************************************

   // an event in the clearing cycle keeps its bit, so nothing is lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= {W{1'b0}};
      end else begin
         status_q <= evt | (status_q & ~clr);
      end
   end

endmodule

// ---- hdl/vdib_top.v ----
// per-channel demapper interrupt status and enable bank with apb slave
`timescale 1ns/1ns
`include "vdib_map.vh"

module vdib_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire ptm_unstable,
   input wire new_ptm_pulse,
   input wire tim_defect,
   input wire size_err_defect,
   input wire lop_defect,
   input wire rfi_defect,
   input wire rdi_defect,
   input wire ais_failure,
   input wire ais_defect,
   input wire new_label_pulse,
   input wire e1_ais_defect,
   input wire new_aps_pulse,
   input wire tx_fifo_ovf_pulse,
   input wire rx_fifo_ovf_pulse,
   output reg irq
);

   // ************************************************************
   // functions
   // ************************************************************

   // change of a level against its value one cycle earlier
   function chg;
      input cur;
      input prev;
      begin
         chg = cur ^ prev;
      end
   endfunction

   // word decode: index match and aligned byte address
   function hit;
      input [11:0] addr;
      input [9:0] idx;
      begin
         hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
      end
   endfunction

   // ************************************************************
   // declarations
   // ************************************************************
   reg ptm_unstable_q;
   reg tim_defect_q;
   reg size_err_q;
   reg lop_q;
   reg rfi_q;
   reg rdi_q;
   reg ais_fail_q;
   reg ais_def_q;
   reg e1_ais_q;
   reg [7:0] en0_q;
   reg [7:0] en1_q;
   reg [7:0] en2_q;
   reg [7:0] clr0_q;
   reg [7:0] clr1_q;
   reg [7:0] clr2_q;
   reg [7:0] evt0_d;
   reg [7:0] evt1_d;
   reg [7:0] evt2_d;
   reg [31:0] rdata_d;
   reg err_d;
   wire [7:0] stat0_q;
   wire [7:0] stat1_q;
   wire [7:0] stat2_q;
   wire [7:0] clr0_d;
   wire [7:0] clr1_d;
   wire [7:0] clr2_d;
   wire setup;
   wire done;
   wire wr_done;
   wire rd_done;
   wire lane0;
   wire irq_d;
   wire sel_stat0;
   wire sel_stat1;
   wire sel_stat2;
   wire sel_en0;
   wire sel_en1;
   wire sel_en2;

   // ************************************************************
   // defect history for change detection
   // ************************************************************

   // levels are one cycle old; a defect already present at release
   // of reset is reported once as a change on the first cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ptm_unstable_q <= 1'b0;
         tim_defect_q <= 1'b0;
         size_err_q <= 1'b0;
         lop_q <= 1'b0;
         rfi_q <= 1'b0;
         rdi_q <= 1'b0;
         ais_fail_q <= 1'b0;
         ais_def_q <= 1'b0;
         e1_ais_q <= 1'b0;
      end else begin
         ptm_unstable_q <= ptm_unstable;
         tim_defect_q <= tim_defect;
         size_err_q <= size_err_defect;
         lop_q <= lop_defect;
         rfi_q <= rfi_defect;
         rdi_q <= rdi_defect;
         ais_fail_q <= ais_failure;
         ais_def_q <= ais_defect;
         e1_ais_q <= e1_ais_defect;
      end
   end

   // ************************************************************
   // event vectors
   // ************************************************************

   // status register 0 events; reserved positions stay zero
   always @* begin
      evt0_d = 8'h00;
      evt0_d[`VDIB_S0_PTM_UNST] = chg(ptm_unstable, ptm_unstable_q);
      evt0_d[`VDIB_S0_NEW_PTM] = new_ptm_pulse;
      evt0_d[`VDIB_S0_TIM] = chg(tim_defect, tim_defect_q);
   end

   // receive defect events behind enable register 1
   always @* begin
      evt1_d = 8'h00;
      evt1_d[`VDIB_E1_SIZE_ERR] = size_err_defect & ~size_err_q;
      evt1_d[`VDIB_E1_LOP] = chg(lop_defect, lop_q);
      evt1_d[`VDIB_E1_RFI] = chg(rfi_defect, rfi_q);
      evt1_d[`VDIB_E1_RDI] = chg(rdi_defect, rdi_q);
      evt1_d[`VDIB_E1_AIS_FAIL] = chg(ais_failure, ais_fail_q);
      evt1_d[`VDIB_E1_AIS_DEF] = chg(ais_defect, ais_def_q);
      evt1_d[`VDIB_E1_LABEL] = new_label_pulse;
      evt1_d[`VDIB_E1_E1AIS] = chg(e1_ais_defect, e1_ais_q);
   end

   // aps and elastic store events behind enable register 2
   always @* begin
      evt2_d = 8'h00;
      evt2_d[`VDIB_E2_APS] = new_aps_pulse;
      evt2_d[`VDIB_E2_ES_OVF] = tx_fifo_ovf_pulse | rx_fifo_ovf_pulse;
   end

   // ************************************************************
   // sticky status latches
   // ************************************************************

   // one latch per status word; clears come from completed reads
   vdib_evt_latch #(
      .W(8)
   ) u_stat0 (
      .pclk(pclk),
      .presetn(presetn),
      .evt(evt0_d),
      .clr(clr0_d),
      .status_q(stat0_q)
   );

   vdib_evt_latch #(
      .W(8)
   ) u_stat1 (
      .pclk(pclk),
      .presetn(presetn),
      .evt(evt1_d),
      .clr(clr1_d),
      .status_q(stat1_q)
   );

   vdib_evt_latch #(
      .W(8)
   ) u_stat2 (
      .pclk(pclk),
      .presetn(presetn),
      .evt(evt2_d),
      .clr(clr2_d),
      .status_q(stat2_q)
   );

   // ************************************************************
   // apb decode
   // ************************************************************

   // setup takes the snapshot, the access edge commits it
   assign setup = psel & ~penable;
   assign done = psel & penable & pready;
   assign wr_done = done & pwrite & ~pslverr;
   assign rd_done = done & ~pwrite;
   assign lane0 = pstrb[0];
   assign sel_stat0 = hit(paddr, `VDIB_IDX_STAT0);
   assign sel_stat1 = hit(paddr, `VDIB_IDX_STAT1);
   assign sel_stat2 = hit(paddr, `VDIB_IDX_STAT2);
   assign sel_en0 = hit(paddr, `VDIB_IDX_EN0);
   assign sel_en1 = hit(paddr, `VDIB_IDX_EN1);
   assign sel_en2 = hit(paddr, `VDIB_IDX_EN2);

   // read mux, evaluated in the setup cycle; upper bits read zero
   always @* begin
      rdata_d = 32'h0000_0000;
      err_d = 1'b0;
      if (sel_stat0) begin
         rdata_d[7:0] = stat0_q & `VDIB_S0_MASK;
      end else if (sel_stat1) begin
         rdata_d[7:0] = stat1_q;
      end else if (sel_stat2) begin
         rdata_d[7:0] = stat2_q & `VDIB_E2_MASK;
      end else if (sel_en0) begin
         rdata_d[7:0] = en0_q;
      end else if (sel_en1) begin
         rdata_d[7:0] = en1_q;
      end else if (sel_en2) begin
         rdata_d[7:0] = en2_q;
      end else begin
         err_d = 1'b1;
      end
   end

   // ************************************************************
   // apb response
   // ************************************************************

   // zero wait states: ready rises in the first access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         pready <= 1'b1;
         pslverr <= err_d;
         prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      end else if (done) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ************************************************************
   // clear-on-read masks
   // ************************************************************

   // only bits seen by the snapshot are cleared, so an event landing
   // between setup and access is kept for the next read
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clr0_q <= `VDIB_RST_STAT;
         clr1_q <= `VDIB_RST_STAT;
         clr2_q <= `VDIB_RST_STAT;
      end else if (setup) begin
         clr0_q <= (sel_stat0 & ~pwrite) ? rdata_d[7:0] : 8'h00;
         clr1_q <= (sel_stat1 & ~pwrite) ? rdata_d[7:0] : 8'h00;
         clr2_q <= (sel_stat2 & ~pwrite) ? rdata_d[7:0] : 8'h00;
      end
   end

   assign clr0_d = rd_done ? clr0_q : 8'h00;
   assign clr1_d = rd_done ? clr1_q : 8'h00;
   assign clr2_d = rd_done ? clr2_q : 8'h00;

   // ************************************************************
   // enable registers
   // ************************************************************

   // writes land at the access edge; byte lane 0 carries the data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en0_q <= `VDIB_RST_EN;
         en1_q <= `VDIB_RST_EN;
         en2_q <= `VDIB_RST_EN;
      end else if (wr_done & lane0) begin
         if (sel_en0) begin
            en0_q <= pwdata[7:0] & `VDIB_S0_MASK;
         end
         if (sel_en1) begin
            en1_q <= pwdata[7:0] & `VDIB_E1_MASK;
         end
         if (sel_en2) begin
            en2_q <= pwdata[7:0] & `VDIB_E2_MASK;
         end
      end
   end

   // ************************************************************
   // interrupt request
   // ************************************************************

   // level request; one cycle behind the status latch
   assign irq_d = |(stat0_q & en0_q) | |(stat1_q & en1_q) | |(stat2_q & en2_q);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= irq_d;
      end
   end

endmodule

// ---- test/vdib_props.sv ----
// bus-side assertions for the demapper interrupt bank
`timescale 1ns/1ns
module vdib_props (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   wire mapped;
   // decode of the six register words
   assign mapped = paddr == 12'h19c || paddr == 12'h1a0 || paddr == 12'h1a4
      || paddr == 12'h1ac || paddr == 12'h1c0 || paddr == 12'h1c4;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence rd_s;
      pready && !pwrite;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   AST_RDY: assert property (setup_s ##1 access_s |-> pready)
      else $error("no ready in access cycle");
   AST_ONE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_IDLE: assert property (!psel |=> !pready && !pslverr)
      else $error("answer without request");
   AST_ERR: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   AST_OK: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   AST_HI: assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
   AST_WR: assert property (pready && pwrite |-> prdata == 32'h00000000)
      else $error("read data on write");
   AST_S0: assert property (rd_s ##0 paddr == 12'h19c |-> prdata[7:6] == 2'b00 && prdata[2:0] == 3'b000)
      else $error("reserved status bits set");
   AST_E2: assert property (rd_s ##0 paddr == 12'h1a0 |-> prdata[7:2] == 6'h00)
      else $error("reserved enable bits set");
endmodule

bind vdib_top vdib_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));

// ---- test/vdib_top_tb.sv ----
// self-checking bench for the demapper interrupt bank
`timescale 1ns/1ns
module vdib_top_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic [13:0] drv = 14'h0;
   logic [13:0] pv;
   logic [13:0] x;
   logic iexp = 1'b0;
   logic rnd_on = 1'b0;
   wire [31:0] prdata;
   wire pready;
   wire pslverr;
   wire irq;
   int mismatches = 0;
   int n_tests = 0;
   int r[6];
   int cap;
   int rexp;
   int k;
   int seed;
   logic [11:0] ad[7] = '{12'h19c, 12'h1a0, 12'h1a4, 12'h1ac, 12'h1c0, 12'h1c4, 12'h1a8};
   logic [7:0] wm[6] = '{8'h00, 8'h03, 8'hff, 8'h38, 8'h00, 8'h00};

   vdib_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ptm_unstable(drv[0]), .new_ptm_pulse(drv[1]), .tim_defect(drv[2]),
      .size_err_defect(drv[3]), .lop_defect(drv[4]), .rfi_defect(drv[5]),
      .rdi_defect(drv[6]), .ais_failure(drv[7]), .ais_defect(drv[8]),
      .new_label_pulse(drv[9]), .e1_ais_defect(drv[10]), .new_aps_pulse(drv[11]),
      .tx_fifo_ovf_pulse(drv[12]), .rx_fifo_ovf_pulse(drv[13]), .irq(irq));

   // ******************************
   // clock, model and checking
   // ******************************
   initial forever #4 pclk = ~pclk;

   function automatic int idx(input logic [11:0] a);
      for (int i = 0; i < 6; i++)
         if (a == ad[i]) return i;
      return -1;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // model sees pre-edge inputs, like the design's flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r = '{0, 0, 0, 0, 0, 0};
         pv = 14'h0;
         iexp = 1'b0;
      end else begin
         iexp = |((r[0] & r[3]) | (r[4] & r[2]) | (r[5] & r[1]));
         k = idx(paddr);
         if (psel && !penable) begin
            cap = (k < 0 || pwrite) ? 0 : r[k];
            rexp = cap;
         end
         if (psel && penable && k >= 0) begin
            if (pwrite && pstrb[0] && k > 0 && k < 4) r[k] = pwdata[7:0] & wm[k];
            if (!pwrite && (k == 0 || k > 3)) r[k] = r[k] & ~cap;
         end
         x = drv ^ pv;
         r[0] |= {x[0], drv[1], x[2], 3'b000};
         r[4] |= {drv[3] & ~pv[3], x[4], x[5], x[6], x[7], x[8], drv[9], x[10]};
         r[5] |= {drv[11], drv[12] | drv[13]};
         pv = drv;
      end
   end

   // irq is registered, so it trails the model by one edge
   always @(negedge pclk)
      if (presetn) chk({31'h0, irq}, {31'h0, iexp});

   always @(posedge pclk)
      if (rnd_on) drv <= 14'($urandom);

   // one apb transfer; pready, read data and error are taken at the rising
   // edge that ends the access, and only then is the request released
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      logic [31:0] rd;
      logic er;
      logic ok;
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 16) begin
         @(posedge pclk);
         ok = (pready === 1'b1);
         rd = prdata;
         er = pslverr;
         n++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (!ok) mismatches++;
      chk(rd, rexp);
      chk({31'h0, er}, {31'h0, idx(a) < 0});
   endtask

   task automatic rd_st;
      apb(1'b0, ad[0], 32'h0, 4'hf);
      apb(1'b0, ad[4], 32'h0, 4'hf);
      apb(1'b0, ad[5], 32'h0, 4'hf);
   endtask

   task automatic complete_run;
      if (mismatches == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ******************************
   // scenarios
   // ******************************
   initial begin
      seed = $urandom(11);
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then all-ones writes, a write with the lane 0 strobe off
      foreach (ad[i]) apb(1'b0, ad[i], 32'h0, 4'hf);
      foreach (ad[i]) apb(1'b1, ad[i], 32'hffffffff, 4'hf);
      apb(1'b1, ad[2], 32'h0, 4'he);
      foreach (ad[i]) apb(1'b0, ad[i], 32'h0, 4'hf);
      // each source alone, first enabled then masked
      for (int e = 0; e < 2; e++) begin
         if (e == 1)
            for (int j = 1; j < 4; j++) apb(1'b1, ad[j], 32'h0, 4'hf);
         for (int b = 0; b < 14; b++) begin
            @(posedge pclk);
            drv <= 14'h1 << b;
            @(posedge pclk);
            drv <= drv & 14'h05fd;
            repeat (3) @(posedge pclk);
            rd_st();
            @(posedge pclk);
            drv <= 14'h0;
            repeat (3) @(posedge pclk);
            rd_st();
         end
      end
      // random events racing random accesses
      rnd_on = 1'b1;
      repeat (120) apb(1'($urandom), ad[$urandom_range(6)], $urandom, 4'($urandom));
      rnd_on = 1'b0;
      @(posedge pclk);
      drv <= 14'h0;
      // second reset in mid-run clears everything
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ad[i]) apb(1'b0, ad[i], 32'h0, 4'hf);
      complete_run();
   end

   // watchdog well beyond the roughly 1200 cycles the run needs
   initial begin
      #100000;
      mismatches++;
      complete_run();
   end
endmodule
